// File: hw/srg_regs.svh
// srg_regs.svh: constants of the reset generator
// assumes a 100 MHz sys_clk standing for the double-rate cpu clock
`ifndef SRG_REGS_SVH
`define SRG_REGS_SVH
`define SRG_FPU_SOFT_PORT 16'h00F1
`define SRG_HOT_CYCLES 16
`define SRG_FPU_FULL_CYCLES 256
`define SRG_FPU_HALF_CYCLES 128
`define SRG_FPU_HALF_RATIO 2
`define SRG_CNT_W 9
`define SRG_AGE_W 10
`endif

// File: hw/srg_pkg.sv
// srg_pkg.sv: types of the reset generator
// assumes nothing beyond the constants header
package srg_pkg;
    typedef enum logic [1:0] {SRG_IDLE, SRG_RUN} srg_pulse_t;
endpackage : srg_pkg

// File: hw/srg_pulse.sv
// srg_pulse.sv: retriggerable minimum-width pulse stretcher
// assumes synchronous trigger and counts in sys_clk cycles
`timescale 1ns/10ps
`include "srg_regs.svh"
module srg_pulse (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic trigger,
    input wire logic [`SRG_CNT_W-1:0] length,
    output logic busy
);
    srg_pkg::srg_pulse_t state;
    logic [`SRG_CNT_W-1:0] count;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            state <= srg_pkg::SRG_IDLE;
            count <= '0;
        end
        else if (trigger)
        begin
            state <= srg_pkg::SRG_RUN;
            count <= length - `SRG_CNT_W'(1);
        end
        else
        begin
            unique case (state)
                srg_pkg::SRG_IDLE: count <= '0;
                srg_pkg::SRG_RUN:
                begin
                    if (count == '0)
                        state <= srg_pkg::SRG_IDLE;
                    else
                        count <= count - `SRG_CNT_W'(1);
                end
                default: state <= srg_pkg::SRG_IDLE;
            endcase
        end
    end

    assign busy = (state == srg_pkg::SRG_RUN);
endmodule : srg_pulse

// File: hw/srg_top.sv
// srg_top.sv: system, cpu, coprocessor and channel reset generation
// assumes all inputs synchronous to sys_clk (double-rate cpu clock)
`timescale 1ns/10ps
`include "srg_regs.svh"
module srg_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic power_ok_input,
    input wire logic kbd_shutdown,
    input wire logic cpu_shutdown_cycle,
    input wire logic hot_reset_write,
    input wire logic soft_channel_reset,
    input wire logic io_write,
    input wire logic io_from_cpu,
    input wire logic [15:0] io_addr,
    input wire logic fpu_half_speed,
    output logic system_reset_out,
    output logic cpu_reset_out,
    output logic fpu_reset_out,
    output logic channel_reset_out
);
    logic fpu_soft_hit;
    logic hot_busy;
    logic fpu_busy;
    logic power_bad;
    logic [`SRG_CNT_W-1:0] fpu_len;
    logic [`SRG_AGE_W-1:0] hot_age;
    logic [`SRG_AGE_W-1:0] soft_age;
    logic soft_half;

    function automatic logic [`SRG_CNT_W-1:0] srg_cycles(input int n);
        return `SRG_CNT_W'(n);
    endfunction : srg_cycles

    function automatic logic [`SRG_AGE_W-1:0] srg_age_next(input logic [`SRG_AGE_W-1:0] a);
        return (&a) ? a : a + `SRG_AGE_W'(1);
    endfunction : srg_age_next

    assign power_bad = !power_ok_input;
    assign fpu_soft_hit = io_write && io_from_cpu
        && (io_addr == `SRG_FPU_SOFT_PORT);
    // half speed: 128 coprocessor clocks of two cpu clocks each
    assign fpu_len = fpu_half_speed
        ? srg_cycles(`SRG_FPU_HALF_CYCLES * `SRG_FPU_HALF_RATIO - 1)
        : srg_cycles(`SRG_FPU_FULL_CYCLES);

    srg_pulse u_hot (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .trigger(hot_reset_write),
        .length(srg_cycles(`SRG_HOT_CYCLES)),
        .busy(hot_busy)
    );

    srg_pulse u_fpu (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .trigger(fpu_soft_hit),
        .length(fpu_len),
        .busy(fpu_busy)
    );

    // system reset follows power status
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            system_reset_out <= 1'b1;
        else
            system_reset_out <= power_bad;
    end

    // cpu-only reset sources
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            cpu_reset_out <= 1'b1;
        else
            cpu_reset_out <= power_bad || hot_reset_write || hot_busy
                || kbd_shutdown || cpu_shutdown_cycle;
    end

    // coprocessor-only reset sources
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            fpu_reset_out <= 1'b1;
        else
            fpu_reset_out <= power_bad || fpu_soft_hit || fpu_busy;
    end

    // channel reset
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            channel_reset_out <= 1'b1;
        else
            channel_reset_out <= power_bad || soft_channel_reset;
    end

    // cycles since the last hot reset, saturating
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            hot_age <= '1;
        else if (hot_reset_write)
            hot_age <= '0;
        else
            hot_age <= srg_age_next(hot_age);
    end

    // cycles since the last accepted soft write, and its speed
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            soft_age <= '1;
            soft_half <= 1'b0;
        end
        else if (fpu_soft_hit)
        begin
            soft_age <= '0;
            soft_half <= fpu_half_speed;
        end
        else
            soft_age <= srg_age_next(soft_age);
    end

    // source and level checks
    AST_SYS_FOLLOWS_POWER: assert property (@(posedge sys_clk) disable iff (!resetn)
        !power_ok_input |=> system_reset_out)
        else $error("system reset missing while power bad");
    AST_POWER_ALL: assert property (@(posedge sys_clk) disable iff (!resetn)
        !power_ok_input |=> (cpu_reset_out && fpu_reset_out && channel_reset_out))
        else $error("power-on did not assert all resets");
    AST_HOT_WIDTH: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_ok_input && hot_reset_write) |=> cpu_reset_out [*8] ##1 cpu_reset_out [*8])
        else $error("hot reset pulse shorter than sixteen clocks");
    AST_KBD: assert property (@(posedge sys_clk) disable iff (!resetn)
        kbd_shutdown |=> cpu_reset_out)
        else $error("keyboard shutdown without cpu reset");
    AST_FPU_SOFT: assert property (@(posedge sys_clk) disable iff (!resetn)
        fpu_soft_hit |=> fpu_reset_out)
        else $error("soft port write without coprocessor reset");
    AST_FPU_FULL: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fpu_soft_hit && !fpu_half_speed) |=> ##255 fpu_reset_out)
        else $error("coprocessor reset shorter than 256 clocks");
    AST_FPU_HALF: assert property (@(posedge sys_clk) disable iff (!resetn)
        (fpu_soft_hit && fpu_half_speed) |=> ##255 fpu_reset_out)
        else $error("half speed coprocessor reset too short");
    AST_NOT_CPU: assert property (@(posedge sys_clk) disable iff (!resetn)
        (io_write && !io_from_cpu && !fpu_busy && power_ok_input) |=> !fpu_reset_out)
        else $error("coprocessor reset from a foreign master");
    AST_CHAN_ONLY: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_ok_input && soft_channel_reset) |=> !system_reset_out)
        else $error("channel reset raised system reset");

    // every output held while in reset
    AST_HOLD_ALL: assert property (@(posedge sys_clk)
        !resetn |=> (system_reset_out && cpu_reset_out && fpu_reset_out && channel_reset_out))
        else $error("reset outputs not all held during reset");

    // shutdown raises cpu reset; outputs only raised by their own sources
    AST_SYS_RELEASE: assert property (@(posedge sys_clk) disable iff (!resetn)
        power_ok_input |=> !system_reset_out)
        else $error("system reset without power fault");
    AST_SHUTDOWN: assert property (@(posedge sys_clk) disable iff (!resetn)
        cpu_shutdown_cycle |=> cpu_reset_out)
        else $error("processor shutdown without cpu reset");
    AST_CPU_SOURCES: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_ok_input && !hot_reset_write && !hot_busy && !kbd_shutdown
            && !cpu_shutdown_cycle) |=> !cpu_reset_out)
        else $error("cpu reset without a cpu reset source");
    AST_FPU_SOURCES: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_ok_input && !fpu_soft_hit && !fpu_busy) |=> !fpu_reset_out)
        else $error("coprocessor reset without a coprocessor source");
    AST_CHAN_SOURCES: assert property (@(posedge sys_clk) disable iff (!resetn)
        (power_ok_input && !soft_channel_reset) |=> !channel_reset_out)
        else $error("channel reset without a channel source");

    // hot reset window
    AST_HOT_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        (hot_age < `SRG_AGE_W'(`SRG_HOT_CYCLES)) |-> cpu_reset_out)
        else $error("cpu reset dropped inside the hot reset window");
    AST_HOT_END: assert property (@(posedge sys_clk) disable iff (!resetn)
        ((hot_age > `SRG_AGE_W'(`SRG_HOT_CYCLES)) && $past(resetn) && $past(power_ok_input)
            && !$past(kbd_shutdown) && !$past(cpu_shutdown_cycle)) |-> !cpu_reset_out)
        else $error("cpu reset outlived the hot reset window");

    // coprocessor soft reset window
    AST_FULL_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!soft_half && (soft_age < `SRG_AGE_W'(`SRG_FPU_FULL_CYCLES))) |-> fpu_reset_out)
        else $error("full speed coprocessor reset dropped early");
    AST_FULL_END: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!soft_half && (soft_age > `SRG_AGE_W'(`SRG_FPU_FULL_CYCLES)) && $past(resetn)
            && $past(power_ok_input)) |-> !fpu_reset_out)
        else $error("full speed coprocessor reset held too long");
    AST_HALF_HOLD: assert property (@(posedge sys_clk) disable iff (!resetn)
        (soft_half && (soft_age < `SRG_AGE_W'(`SRG_FPU_HALF_CYCLES * `SRG_FPU_HALF_RATIO)))
            |-> fpu_reset_out)
        else $error("half speed coprocessor reset dropped early");
    AST_HALF_END: assert property (@(posedge sys_clk) disable iff (!resetn)
        (soft_half && (soft_age >= `SRG_AGE_W'(`SRG_FPU_HALF_CYCLES * `SRG_FPU_HALF_RATIO))
            && $past(resetn) && $past(power_ok_input)) |-> !fpu_reset_out)
        else $error("half speed coprocessor reset held too long");

    // foreign and misaddressed writes
    AST_FOREIGN: assert property (@(posedge sys_clk) disable iff (!resetn)
        (io_write && !io_from_cpu && !fpu_busy) |=> !fpu_busy)
        else $error("foreign master started the coprocessor pulse");
    AST_OTHER_PORT: assert property (@(posedge sys_clk) disable iff (!resetn)
        (io_write && (io_addr != `SRG_FPU_SOFT_PORT) && !fpu_busy) |=> !fpu_busy)
        else $error("other port started the coprocessor pulse");
endmodule : srg_top

// File: tb/srg_far.sv
// srg_far.sv: keyboard controller and reset receivers
// assumes sys_clk is the double-rate cpu clock
`timescale 1ns/10ps
module srg_far (
    input wire logic sys_clk,
    input wire logic kbd_go,
    input wire logic [7:0] kbd_len,
    input wire logic cpu_reset_out,
    input wire logic fpu_reset_out,
    output logic kbd_shutdown,
    output logic cpu_rst_sync,
    output logic fpu_rst_sync
);
    logic [7:0] left = 8'h00;
    logic fpu_clk = 1'b0;
    assign kbd_shutdown = left != 8'h00;
    always @(posedge sys_clk)
    begin
        left <= kbd_go ? kbd_len : left - {7'h00, kbd_shutdown};
        cpu_rst_sync <= cpu_reset_out;
        fpu_clk <= ~fpu_clk;
    end
    always_ff @(posedge fpu_clk)
    begin
        fpu_rst_sync <= fpu_reset_out;
    end
endmodule : srg_far

// File: tb/tb.sv
// tb.sv: self-checking bench of the reset generator
// assumes srg_top and srg_far compiled before it
`timescale 1ns/10ps
module tb;
    logic sys_clk = 1'b0, resetn = 1'b0, pok = 1'b0, sd = 1'b0, hot = 1'b0, kbd;
    logic chan = 1'b0, wr = 1'b0, cpu = 1'b0, half = 1'b0, kgo = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] klen = 8'h0A;
    wire [3:0] o;
    wire csync, fsync;
    int n_fail = 0, samples_checked = 0, cyc = 0;
    always #5 sys_clk = ~sys_clk;
    srg_top DUT (.sys_clk(sys_clk), .resetn(resetn), .power_ok_input(pok),
        .kbd_shutdown(kbd), .cpu_shutdown_cycle(sd), .hot_reset_write(hot),
        .soft_channel_reset(chan), .io_write(wr), .io_from_cpu(cpu), .io_addr(addr),
        .fpu_half_speed(half), .system_reset_out(o[3]), .cpu_reset_out(o[2]),
        .fpu_reset_out(o[1]), .channel_reset_out(o[0]));
    srg_far far (.sys_clk(sys_clk), .kbd_go(kgo), .kbd_len(klen), .cpu_reset_out(o[2]),
        .fpu_reset_out(o[1]), .kbd_shutdown(kbd), .cpu_rst_sync(csync), .fpu_rst_sync(fsync));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : step
    // counts the high cycles of output i and flags any other output
    task automatic width(input int i, input int exp, input string what);
        int n;
        logic [3:0] oth;
        n = 0;
        oth = 4'h0;
        for (int t = 0; t < 600; t++)
        begin
            if (o[i] === 1'b1) n++;
            else if (n > 0) break;
            oth |= o & ~(4'h1 << i);
            step(1);
        end
        chk(what, n, exp);
        chk({what, " others"}, {28'h0, oth}, 0);
    endtask : width
    task automatic t_power;
        step(8);
        chk("power low", {28'h0, o}, 4'hF);
        chk("receivers held", {30'h0, csync, fsync}, 32'h3);
        pok = 1'b1;
        step(2);
        chk("power ok", {28'h0, o}, 4'h0);
        step(4);
        chk("receivers released", {30'h0, csync, fsync}, 32'h0);
    endtask : t_power
    task automatic t_cpu;
        hot = 1'b1;
        step(1);
        hot = 1'b0;
        width(2, 17, "hot cpu");
        sd = 1'b1;
        fork
            begin
                step(3);
                sd = 1'b0;
            end
            width(2, 3, "shutdown cpu");
        join
        kgo = 1'b1;
        step(1);
        kgo = 1'b0;
        width(2, 10, "kbd cpu");
        klen = 8'h05;
        kgo = 1'b1;
        step(1);
        kgo = 1'b0;
        width(2, 5, "kbd short cpu");
    endtask : t_cpu
    task automatic t_chan;
        chan = 1'b1;
        fork
            begin
                step(5);
                chan = 1'b0;
            end
            width(0, 5, "channel");
        join
    endtask : t_chan
    task automatic io(input logic [15:0] a, input logic c);
        addr = a;
        cpu = c;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask : io
    // reset in mid-run cuts a hot reset pulse short
    task automatic t_reset;
        hot = 1'b1;
        step(1);
        hot = 1'b0;
        step(3);
        resetn = 1'b0;
        step(2);
        chk("reset held", {28'h0, o}, 4'hF);
        resetn = 1'b1;
        step(2);
        chk("reset released", {28'h0, o}, 4'h0);
    endtask : t_reset
    task automatic t_fpu;
        io(16'h00F1, 1'b1);
        width(1, 257, "fpu full");
        half = 1'b1;
        io(16'h00F1, 1'b1);
        width(1, 256, "fpu half");
        io(16'h00F1, 1'b0);
        width(1, 0, "not cpu");
        io(16'h00F0, 1'b1);
        width(1, 0, "other port");
    endtask : t_fpu
    task automatic summarize;
        if (n_fail == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            summarize();
        end
    end
    initial
    begin
        step(12);
        resetn = 1'b1;
        t_power();
        t_cpu();
        t_chan();
        t_fpu();
        t_reset();
        summarize();
    end
endmodule : tb
